// ===== ptivm_msix_arb.sv
// Pending MSI-X events and the one-at-a-time message request.
`timescale 1ns/1ps
`default_nettype none
module ptivm_msix_arb
  import ptivm_pkg::*;
(
  input  wire logic                            clk_i,
  input  wire logic                            rst_n_i,
  input  wire logic                            clr_i,
  input  wire logic [ptivm_pkg::NUM_SRC-1:0]   evt_i,
  input  wire logic [ptivm_pkg::NUM_SRC*16-1:0] vec_flat_i,
  input  wire logic                            ack_i,
  output logic                                 req_o,
  output logic [15:0]                          vec_o
);
  import ptivm_pkg::*;

  logic [NUM_SRC-1:0] pend_q;
  logic [NUM_SRC-1:0] mapped;
  logic [NUM_SRC-1:0] grant_1h;
  logic [15:0]        grant_vec;
  logic               req_q;
  logic [15:0]        vec_q;
  logic               take;

  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      mapped[i] = vec_flat_i[i*16 +: 16] != UNMAPPED_VECTOR_CODE;
    end
  end

  // Lowest source wins; the configuration event is source zero.
  always_comb begin
    logic found;
    found     = 1'b0;
    grant_1h  = '0;
    grant_vec = UNMAPPED_VECTOR_CODE;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (!found && pend_q[i] && mapped[i]) begin
        found       = 1'b1;
        grant_1h[i] = 1'b1;
        grant_vec   = vec_flat_i[i*16 +: 16];
      end
    end
  end

  assign take = !req_q && (grant_1h != '0);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_q <= '0;
      req_q  <= 1'b0;
      vec_q  <= UNMAPPED_VECTOR_CODE;
    end else begin
      // An unmapped event is dropped; a new event wins over the grant clear.
      pend_q <= clr_i ? '0 : (((pend_q & mapped) & ~(take ? grant_1h : '0)) | (evt_i & mapped));
      if (clr_i || (req_q && ack_i)) begin
        req_q <= 1'b0;
      end else if (take) begin
        req_q <= 1'b1;
        vec_q <= grant_vec;
      end
    end
  end

  assign req_o = req_q;
  assign vec_o = vec_q;

endmodule : ptivm_msix_arb
`default_nettype wire

// ===== ptivm_msix_sink.sv
// Behavioural model of the host side that consumes MSI-X message requests.
`timescale 1ns/1ps
`default_nettype none
module ptivm_msix_sink (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        req_i,
  input  wire logic [15:0] vec_i,
  input  wire logic [3:0]  dly_i,
  output logic             ack_o,
  output logic [15:0]      last_o,
  output int               cnt_o
);
  logic [3:0] wait_q;
  // A slow host leaves the request standing, so hold-until-ack is exercised.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o  <= 1'b0;
      wait_q <= 4'h0;
      cnt_o  <= 0;
      last_o <= 16'hffff;
    end else if (ack_o) begin
      ack_o <= 1'b0;
    end else if (req_i) begin
      if (wait_q >= dly_i) begin
        ack_o  <= 1'b1;
        last_o <= vec_i;
        cnt_o  <= cnt_o + 1;
        wait_q <= 4'h0;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule : ptivm_msix_sink
`default_nettype wire

// ===== ptivm_pkg.sv
// Package of constants and helpers for the PCI transport interrupt vector map.
`default_nettype none
package ptivm_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int          NUM_Q         = 4;
  localparam int          QW            = 2;
  localparam int          NUM_SRC       = NUM_Q + 1;
  localparam int          SRC_W         = 3;
  localparam int          ADR_W         = 8;
  localparam int          VEC_W         = 16;
  localparam logic [15:0] UNMAPPED_VECTOR_CODE = 16'hffff;
  localparam logic [15:0] MSIX_TBL_ENTRIES     = 16'h0008;
  localparam logic [15:0] QSIZE_MAX            = 16'h0100;
  localparam logic [31:0] DEV_FEATURES         = 32'h0000_0000;
  localparam logic [15:0] QUEUE_PAGE_BYTES     = 16'h1000;

  // ****************************************************************
  // Register indices; the byte address is four times the index
  // ****************************************************************
  localparam logic [5:0] IDX_DEV_FEAT   = 6'h00;
  localparam logic [5:0] IDX_DRV_FEAT   = 6'h04;
  localparam logic [5:0] IDX_Q_ADDR     = 6'h08;
  localparam logic [5:0] IDX_Q_SIZE     = 6'h0c;
  localparam logic [5:0] IDX_Q_SEL      = 6'h0e;
  localparam logic [5:0] IDX_Q_NOTIFY   = 6'h10;
  localparam logic [5:0] IDX_DEV_STATUS = 6'h12;
  localparam logic [5:0] IDX_ISR        = 6'h13;
  localparam logic [5:0] IDX_CFG_VEC    = 6'h14;
  localparam logic [5:0] IDX_Q_VEC      = 6'h16;
  localparam logic [5:0] IDX_CTRL       = 6'h18;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_MSIX_EN   = 0;
  localparam int CTRL_INTX_MASK = 1;
  localparam int CTRL_NT_GUARD  = 2;
  localparam int CTRL_LEGACY    = 3;
  localparam int CTRL_W         = 4;
  localparam int CTRL_INTSTAT   = 8;
  localparam int CTRL_DEAD      = 9;
  localparam int CTRL_TSIZE_LSB = 16;
  localparam int ISR_QUEUE      = 0;
  localparam int ISR_CFG        = 1;
  localparam logic [3:0] SEL_LOW_BYTE = 4'h1;

  // Byte-lane merge of a write into a stored word.
  function automatic logic [31:0] ptivm_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : ptivm_merge

endpackage : ptivm_pkg
`default_nettype wire

// ===== ptivm_top.sv
// PCI transport interrupt vector map with legacy layout registers on a Wishbone slave.
//
// Function
// - With guard set, low-byte zero write at index 18 kills the device until reset.
// - Legacy register layout is reachable at its own indices beside the own registers; here legacy is only a control bit on the same indices.
// - With MSI-X enabled events go only through vectors, never the cause byte.
// - Vectors 0 to table end map an event; all ones unmaps it.
// - Table holds a modest count of entries, reported as size minus one.
// - Any event may map to any valid vector, and any may unmap.
// - Reading a vector field returns the current mapping or the unmapped code; here it reads zero while MSI-X is off.
// - Reset, hard or soft, unmaps the configuration and every queue event.
// - A refused mapping reads back as the unmapped code.
// - Queue select picks a queue; size zero means absent; smaller size accepted.
// - Legacy mode keeps page frame addresses and refuses queue size changes.
// - A write of a queue index to the notify field kicks that queue.
// - Without MSI-X a queue event sets cause bit zero, then the line.
// - With MSI-X a queue event sends its mapped vector, or nothing.
// - Without MSI-X a config change sets cause bit one, then the line.
// - With MSI-X a config change sends its mapped vector, or nothing.
// - Both causes may be pending together behind one line interrupt.
// - Reading the cause byte returns it, clears it and drops the line.
// - Interrupt status is the OR of cause bits, held low at intx_status_o with MSI-X on; the line obeys its mask.
//
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module ptivm_top
  import ptivm_pkg::*;
(
  input  wire logic                          core_clk_i,
  input  wire logic                          arst_n_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [ptivm_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic [31:0]                        wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic                          cfg_evt_i,
  input  wire logic [ptivm_pkg::NUM_Q-1:0]   queue_evt_i,
  output logic                               kick_o,
  output logic [15:0]                        kick_qidx_o,
  output logic                               irq_line_o,
  output logic                               intx_status_o,
  output logic                               msix_req_o,
  output logic [15:0]                        msix_vec_o,
  input  wire logic                          msix_ack_i,
  output logic [7:0]                         device_status_o,
  output logic                               dead_o
);
  import ptivm_pkg::*;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_s1_q;
  logic rst_n;

  // Reset asserts at once but leaves on the clock, so no flop sees a half-released reset.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // ****************************************************************
  // State
  // ****************************************************************
  logic                 ack_q;
  logic [31:0]          dat_q;
  logic [31:0]          drv_feat_q;
  logic [15:0]          qsel_q;
  logic [15:0]          qsize_q [NUM_Q];
  logic [31:0]          qaddr_q [NUM_Q];
  logic [7:0]           status_q;
  logic [1:0]           isr_q;
  logic [CTRL_W-1:0]    ctrl_q;
  logic                 dead_q;
  logic                 kick_q;
  logic [15:0]          kick_idx_q;
  logic                 line_q;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire        req      = wb_cyc_i && wb_stb_i && !ack_q;
  wire        wr       = req && wb_we_i;
  wire        rd       = req && !wb_we_i;
  wire        wr_live  = wr && !dead_q;
  wire [5:0]  idx      = wb_adr_i[ADR_W-1:2];
  wire        hit_dfeat  = idx == IDX_DEV_FEAT;
  wire        hit_drvft  = idx == IDX_DRV_FEAT;
  wire        hit_qaddr  = idx == IDX_Q_ADDR;
  wire        hit_qsize  = idx == IDX_Q_SIZE;
  wire        hit_qsel   = idx == IDX_Q_SEL;
  wire        hit_notify = idx == IDX_Q_NOTIFY;
  wire        hit_status = idx == IDX_DEV_STATUS;
  wire        hit_isr    = idx == IDX_ISR;
  wire        hit_cfgvec = idx == IDX_CFG_VEC;
  wire        hit_qvec   = idx == IDX_Q_VEC;
  wire        hit_ctrl   = idx == IDX_CTRL;

  wire        msix_en  = ctrl_q[CTRL_MSIX_EN];
  wire        legacy   = ctrl_q[CTRL_LEGACY];
  wire        qsel_ok  = qsel_q < 16'(NUM_Q);
  wire [QW-1:0] qi     = qsel_q[QW-1:0];

  // ****************************************************************
  // Write data merged with current contents
  // ****************************************************************
  logic [NUM_SRC*16-1:0] vec_flat;
  wire [15:0] cfg_vec   = vec_flat[15:0];
  wire [15:0] q_vec     = qsel_ok ? vec_flat[(32'(qi) + 1) * 16 +: 16] : UNMAPPED_VECTOR_CODE;
  wire [15:0] cur_qsize = qsel_ok ? qsize_q[qi] : 16'h0000;
  wire [31:0] cur_qaddr = qsel_ok ? qaddr_q[qi] : 32'h0000_0000;
  // A function result cannot be sliced in place, so each merge lands on a full word first.
  wire [31:0] mg_qsize  = ptivm_merge({16'h0000, cur_qsize}, wb_dat_i, wb_sel_i);
  wire [31:0] m_qaddr   = ptivm_merge(cur_qaddr, wb_dat_i, wb_sel_i);
  wire [31:0] mg_qsel   = ptivm_merge({16'h0000, qsel_q}, wb_dat_i, wb_sel_i);
  wire [31:0] mg_notify = ptivm_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
  wire [31:0] mg_status = ptivm_merge({24'h000000, status_q}, wb_dat_i, wb_sel_i);
  wire [31:0] mg_cfgvec = ptivm_merge({16'h0000, cfg_vec}, wb_dat_i, wb_sel_i);
  wire [31:0] mg_qvec   = ptivm_merge({16'h0000, q_vec}, wb_dat_i, wb_sel_i);
  wire [31:0] m_ctrl    = ptivm_merge({28'h0000000, ctrl_q}, wb_dat_i, wb_sel_i);
  wire [15:0] m_qsize   = mg_qsize[15:0];
  wire [15:0] m_qsel    = mg_qsel[15:0];
  wire [15:0] m_notify  = mg_notify[15:0];
  wire [7:0]  m_status  = mg_status[7:0];
  wire [15:0] m_cfgvec  = mg_cfgvec[15:0];
  wire [15:0] m_qvec    = mg_qvec[15:0];

  // Only an exact single low-byte zero write trips the guard, as an old driver would do it.
  wire kill      = wr_live && hit_status && ctrl_q[CTRL_NT_GUARD] && (wb_sel_i == SEL_LOW_BYTE)
                   && (wb_dat_i[7:0] == 8'h00);
  wire soft_rst  = wr_live && hit_status && !kill && (m_status == 8'h00);
  wire qsize_ok  = !legacy && qsel_ok && (m_qsize != 16'h0000) && (m_qsize <= QSIZE_MAX);
  wire vec_wr    = wr_live && msix_en && (hit_cfgvec || (hit_qvec && qsel_ok));
  wire [SRC_W-1:0] vec_src = hit_cfgvec ? SRC_W'(0) : SRC_W'(qi) + SRC_W'(1);
  wire [15:0] vec_val  = hit_cfgvec ? m_cfgvec : m_qvec;
  wire notify_ok = wr_live && hit_notify && (m_notify < 16'(NUM_Q));

  // ****************************************************************
  // Interrupt cause byte
  // ****************************************************************
  wire        isr_clr  = rd && hit_isr && !dead_q;
  wire [1:0]  isr_set  = (msix_en || dead_q) ? 2'b00 : {cfg_evt_i, |queue_evt_i};
  wire [1:0]  isr_d    = ((isr_clr || soft_rst) ? 2'b00 : isr_q) | isr_set;

  // ****************************************************************
  // Read data
  // ****************************************************************
  wire [31:0] ctrl_rd = {5'h00, (MSIX_TBL_ENTRIES[10:0] - 11'h001), 6'h00, dead_q, (|isr_q),
                         4'h0, ctrl_q};
  wire [31:0] rd_mux =
      dead_q     ? 32'h0000_0000 :
      hit_dfeat  ? DEV_FEATURES :
      hit_drvft  ? drv_feat_q :
      hit_qaddr  ? cur_qaddr :
      hit_qsize  ? {16'h0000, cur_qsize} :
      hit_qsel   ? {16'h0000, qsel_q} :
      hit_status ? {24'h000000, status_q} :
      hit_isr    ? {30'h00000000, isr_q} :
      (hit_cfgvec && msix_en) ? {16'h0000, cfg_vec} :
      (hit_qvec && msix_en)   ? {16'h0000, q_vec} :
      hit_ctrl   ? ctrl_rd : 32'h0000_0000;

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  // Answer one cycle after the request is taken; unmapped indices read zero.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (rd) begin
        dat_q <= rd_mux;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      drv_feat_q <= 32'h0000_0000;
      qsel_q     <= 16'h0000;
      status_q   <= 8'h00;
      ctrl_q     <= '0;
      dead_q     <= 1'b0;
      isr_q      <= 2'b00;
      for (int i = 0; i < NUM_Q; i++) begin
        qsize_q[i] <= QSIZE_MAX;
        qaddr_q[i] <= 32'h0000_0000;
      end
    end else begin
      isr_q <= isr_d;
      if (kill) begin
        dead_q <= 1'b1;
      end
      if (soft_rst) begin
        drv_feat_q <= 32'h0000_0000;
        qsel_q     <= 16'h0000;
        status_q   <= 8'h00;
        for (int i = 0; i < NUM_Q; i++) begin
          qsize_q[i] <= QSIZE_MAX;
          qaddr_q[i] <= 32'h0000_0000;
        end
      end else if (wr_live && !kill) begin
        if (hit_drvft) begin
          drv_feat_q <= ptivm_merge(drv_feat_q, wb_dat_i, wb_sel_i);
        end
        if (hit_qsel) begin
          qsel_q <= m_qsel;
        end
        if (hit_qaddr && qsel_ok) begin
          qaddr_q[qi] <= m_qaddr;
        end
        if (hit_qsize && qsize_ok) begin
          qsize_q[qi] <= m_qsize;
        end
        if (hit_status) begin
          status_q <= m_status;
        end
        if (hit_ctrl) begin
          ctrl_q <= m_ctrl[CTRL_W-1:0];
        end
      end
    end
  end

  // ****************************************************************
  // Kick and line interrupt
  // ****************************************************************
  // The line follows the cause byte one cycle later, so the bit is always set first.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      kick_q     <= 1'b0;
      kick_idx_q <= 16'h0000;
      line_q     <= 1'b0;
    end else begin
      kick_q <= notify_ok;
      if (notify_ok) begin
        kick_idx_q <= m_notify;
      end
      line_q <= !msix_en && (|isr_q) && !ctrl_q[CTRL_INTX_MASK];
    end
  end

  // ****************************************************************
  // Vector table and MSI-X requests
  // ****************************************************************
  ptivm_vec_table u_vec_table (
    .clk_i      (core_clk_i),
    .rst_n_i    (rst_n),
    .soft_clr_i (soft_rst),
    .wr_i       (vec_wr),
    .wr_src_i   (vec_src),
    .wr_val_i   (vec_val),
    .vec_flat_o (vec_flat)
  );

  wire [NUM_SRC-1:0] msix_evt = (msix_en && !dead_q) ? {queue_evt_i, cfg_evt_i} : '0;

  ptivm_msix_arb u_msix_arb (
    .clk_i      (core_clk_i),
    .rst_n_i    (rst_n),
    .clr_i      (!msix_en || dead_q || soft_rst),
    .evt_i      (msix_evt),
    .vec_flat_i (vec_flat),
    .ack_i      (msix_ack_i),
    .req_o      (msix_req_o),
    .vec_o      (msix_vec_o)
  );

  assign wb_ack_o        = ack_q;
  assign wb_dat_o        = dat_q;
  assign kick_o          = kick_q;
  assign kick_qidx_o     = kick_idx_q;
  assign irq_line_o      = line_q;
  assign intx_status_o   = !msix_en && (|isr_q);
  assign device_status_o = status_q;
  assign dead_o          = dead_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_isr_read;
    isr_clr && !cfg_evt_i && !(|queue_evt_i);
  endsequence
  sequence s_isr_empty;
    isr_q == 2'b00 ##1 !irq_line_o;
  endsequence

  a_kill_reads_zero: assert property (dead_q && rd |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("read after kill returned data");
  a_map_accepted: assert property (vec_wr && hit_cfgvec && (m_cfgvec < MSIX_TBL_ENTRIES) && !soft_rst
    |=> cfg_vec == $past(m_cfgvec))
    else $error("valid vector not stored");
  a_map_refused: assert property (vec_wr && hit_cfgvec && (m_cfgvec >= MSIX_TBL_ENTRIES)
    |=> cfg_vec == UNMAPPED_VECTOR_CODE)
    else $error("refused vector not unmapped");
  a_soft_unmap: assert property (soft_rst |=> vec_flat == {NUM_SRC{UNMAPPED_VECTOR_CODE}})
    else $error("soft reset left a vector mapped");
  a_msix_no_cause: assert property (msix_en && cfg_evt_i && !isr_q[ISR_CFG] |=> !isr_q[ISR_CFG])
    else $error("cause bit set with vectors enabled");
  a_queue_cause: assert property (!msix_en && !dead_q && (|queue_evt_i) |=> isr_q[ISR_QUEUE])
    else $error("queue cause bit missing");
  a_cfg_cause_line: assert property (!msix_en && !dead_q && cfg_evt_i && !ctrl_q[CTRL_INTX_MASK]
    ##1 !msix_en && !ctrl_q[CTRL_INTX_MASK] && isr_q[ISR_CFG] |=> irq_line_o)
    else $error("config cause did not raise the line");
  a_isr_read_clear: assert property (s_isr_read ##1 !cfg_evt_i && !(|queue_evt_i) |-> s_isr_empty)
    else $error("cause byte not cleared by read");
  a_msix_vec_valid: assert property (msix_req_o |-> msix_vec_o < MSIX_TBL_ENTRIES)
    else $error("message request for an unmapped vector");
  a_kick_index: assert property (notify_ok |=> kick_o && kick_qidx_o == $past(m_notify))
    else $error("kick missing or wrong index");
  a_line_masked: assert property (ctrl_q[CTRL_INTX_MASK] |=> !irq_line_o)
    else $error("line raised while masked");
  a_msix_req_hold: assert property (msix_req_o && !msix_ack_i && msix_en && !dead_q && !soft_rst
    |=> msix_req_o && $stable(msix_vec_o))
    else $error("message request dropped before acceptance");
  a_legacy_qsize: assert property (wr_live && hit_qsize && legacy |=> $stable(cur_qsize))
    else $error("queue size changed in legacy mode");

endmodule : ptivm_top
`default_nettype wire

// ===== ptivm_top_tb.sv
// Self-checking testbench of the interrupt vector map over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module ptivm_top_tb;
  import ptivm_pkg::*;
  logic clk, rst_n, cyc, stb, we, ack, cfg_evt, kick, irq, ist, mreq, mack, dead;
  logic [7:0] adr, dstat;
  logic [3:0] sel, qevt, dly;
  logic [31:0] wdat, rdat, q;
  logic [15:0] kidx, mvec, last;
  int num_errors, num_checks, cnt;
  ptivm_top dut (.core_clk_i(clk), .arst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cfg_evt_i(cfg_evt),
    .queue_evt_i(qevt), .kick_o(kick), .kick_qidx_o(kidx), .irq_line_o(irq), .intx_status_o(ist),
    .msix_req_o(mreq), .msix_vec_o(mvec), .msix_ack_i(mack), .device_status_o(dstat), .dead_o(dead));
  ptivm_msix_sink host (.clk_i(clk), .rst_n_i(rst_n), .req_i(mreq), .vec_i(mvec), .dly_i(dly),
    .ack_o(mack), .last_o(last), .cnt_o(cnt));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // The request stands until ack is seen at a rising edge; no fixed latency is assumed.
  task automatic bus(input logic w, input logic [5:0] i, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {i, 2'b00}; sel <= s; wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      finish_test();
    end
  endtask : bus
  task automatic pulse(input logic c, input logic [3:0] qv);
    @(posedge clk); cfg_evt <= c; qevt <= qv;
    @(posedge clk); cfg_evt <= 1'b0; qevt <= 4'h0;
    repeat (12) @(posedge clk);
  endtask : pulse
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {cyc, stb, we, cfg_evt, rst_n} = 5'h0; adr = 8'h00; sel = 4'hf; wdat = 32'h0; qevt = 4'h0; dly = 4'h3;
    num_errors = 0; num_checks = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus(0, IDX_CTRL, 4'hf, 0); chk("tsize", 32'h7, {21'h0, q[26:16]});
    pulse(1'b0, 4'h4); chk("irq", 1, irq);
    pulse(1'b1, 4'h0); chk("istat", 1, ist);
    bus(0, IDX_ISR, 4'hf, 0); chk("cause", 32'h3, q);
    @(posedge clk); chk("irq_clr", 0, irq);
    bus(0, IDX_ISR, 4'hf, 0); chk("cause0", 32'h0, q);
    bus(1, IDX_CTRL, 4'hf, 32'h2);
    pulse(1'b0, 4'h1); chk("irq_mask", 0, irq);
    chk("istat_mask", 1, ist);
    bus(0, IDX_ISR, 4'hf, 0); chk("cause_q", 32'h1, q);
    bus(1, IDX_CTRL, 4'hf, 32'h1);
    bus(0, IDX_CFG_VEC, 4'hf, 0); chk("cfgv_rst", 32'hffff, q);
    bus(1, IDX_CFG_VEC, 4'h3, 32'h3);
    bus(0, IDX_CFG_VEC, 4'hf, 0); chk("cfgv", 32'h3, q);
    bus(1, IDX_Q_SEL, 4'h3, 32'h2);
    bus(1, IDX_Q_VEC, 4'h3, 32'h9);
    bus(0, IDX_Q_VEC, 4'hf, 0); chk("qv_bad", 32'hffff, q);
    bus(1, IDX_Q_VEC, 4'h3, 32'h7);
    bus(0, IDX_Q_VEC, 4'hf, 0); chk("qv", 32'h7, q);
    bus(1, IDX_Q_SEL, 4'h3, 32'h1);
    bus(0, IDX_Q_VEC, 4'hf, 0); chk("qv1", 32'hffff, q);
    pulse(1'b0, 4'h4); chk("msix_q", 32'h7, last);
    pulse(1'b0, 4'h2); chk("msix_cnt", 1, cnt);
    dly <= 4'h0;
    pulse(1'b1, 4'h0); chk("msix_c", 32'h3, last);
    bus(1, IDX_CFG_VEC, 4'h3, 32'hffff);
    pulse(1'b1, 4'h0); chk("unmap", 2, cnt);
    bus(0, IDX_ISR, 4'hf, 0); chk("cause_msix", 32'h0, q);
    chk("irq_msix", 0, irq);
    bus(1, IDX_DEV_STATUS, 4'h1, 32'h7); chk("dstat", 32'h7, dstat);
    bus(1, IDX_DEV_STATUS, 4'h1, 32'h0); chk("dstat_srst", 32'h0, dstat);
    bus(1, IDX_Q_SEL, 4'h3, 32'h2);
    bus(0, IDX_Q_VEC, 4'hf, 0); chk("qv_srst", 32'hffff, q);
    bus(1, IDX_Q_NOTIFY, 4'h3, 32'h2);
    chk("kick", 1, kick);
    chk("kidx", 32'h2, kidx);
    bus(1, IDX_Q_SEL, 4'h3, 32'h0);
    bus(0, IDX_Q_SIZE, 4'hf, 0); chk("qsz", 32'h100, q);
    bus(1, IDX_Q_SIZE, 4'h3, 32'h40);
    bus(0, IDX_Q_SIZE, 4'hf, 0); chk("qsz_small", 32'h40, q);
    bus(1, IDX_CTRL, 4'hf, 32'h9);
    bus(1, IDX_Q_SIZE, 4'h3, 32'h20);
    bus(0, IDX_Q_SIZE, 4'hf, 0); chk("qsz_legacy", 32'h40, q);
    bus(1, IDX_Q_ADDR, 4'hf, 32'h0001_2345);
    bus(0, IDX_Q_ADDR, 4'hf, 0); chk("qaddr", 32'h0001_2345, q);
    bus(1, IDX_Q_SEL, 4'h3, 32'h5);
    bus(0, IDX_Q_SIZE, 4'hf, 0); chk("qsz_abs", 32'h0, q);
    bus(1, IDX_CTRL, 4'hf, 32'h5);
    bus(1, IDX_DEV_STATUS, SEL_LOW_BYTE, 32'h0);
    @(posedge clk); chk("dead", 1, dead);
    bus(1, IDX_DRV_FEAT, 4'hf, 32'h1);
    bus(0, IDX_CTRL, 4'hf, 0); chk("dead_rd", 32'h0, q);
    finish_test();
  end
endmodule : ptivm_top_tb
`default_nettype wire

// ===== ptivm_vec_table.sv
// Vector mapping store for the configuration event and every queue event.
`timescale 1ns/1ps
`default_nettype none
module ptivm_vec_table
  import ptivm_pkg::*;
(
  input  wire logic                            clk_i,
  input  wire logic                            rst_n_i,
  input  wire logic                            soft_clr_i,
  input  wire logic                            wr_i,
  input  wire logic [ptivm_pkg::SRC_W-1:0]     wr_src_i,
  input  wire logic [15:0]                     wr_val_i,
  output logic [ptivm_pkg::NUM_SRC*16-1:0]     vec_flat_o
);
  import ptivm_pkg::*;

  logic [15:0] vec_q [NUM_SRC];
  logic        accept;

  // A vector outside the table cannot be honoured, so it is stored as unmapped.
  assign accept = (wr_val_i < MSIX_TBL_ENTRIES) || (wr_val_i == UNMAPPED_VECTOR_CODE);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        vec_q[i] <= UNMAPPED_VECTOR_CODE;
      end
    end else if (soft_clr_i) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        vec_q[i] <= UNMAPPED_VECTOR_CODE;
      end
    end else if (wr_i) begin
      vec_q[wr_src_i] <= accept ? wr_val_i : UNMAPPED_VECTOR_CODE;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      vec_flat_o[i*16 +: 16] = vec_q[i];
    end
  end

endmodule : ptivm_vec_table
`default_nettype wire
